// ---- design/ewifs_delta_cmp.sv ----
// compares one wake-up measurement against its stored reference
// assumes the measurement fields are stable while valid is high
`default_nettype none

module ewifs_delta_cmp
  import ewifs_pkg::*;
#(
  parameter int W = 8
) (
  // measurement
  input wire logic meas_valid_in,
  input wire logic [W-1:0] value_in,
  input wire logic [W-1:0] reference_in,
  input wire logic [W-1:0] delta_in,
  // result
  output logic hit_out
);

  logic [W-1:0] diff;

  // ==========================================================
  // absolute difference, strictly above delta
  always_comb begin
    if (value_in >= reference_in) begin
      diff = value_in - reference_in;
    end else begin
      diff = reference_in - value_in;
    end
    hit_out = meas_valid_in & (diff > delta_in);
  end

endmodule : ewifs_delta_cmp

`default_nettype wire

// ---- design/ewifs_pkg.sv ----
// package for the error / wake-up interrupt and queue status block
// assumes a single clock domain and an APB slave with 32-bit data
`default_nettype none

package ewifs_pkg;

  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_ERR_MASK = 8'h16;
  localparam logic [7:0] IDX_MAIN_IRQ = 8'h17;
  localparam logic [7:0] IDX_ERR_WAKE = 8'h19;
  localparam logic [7:0] IDX_QFILL = 8'h1A;
  localparam logic [7:0] IDX_QFLAGS = 8'h1B;
  localparam logic [7:0] IDX_CTRL = 8'h20;

  // ==========================================================
  // error and wake-up status bit positions
  localparam int ERR_CRC = 7;
  localparam int ERR_PAR = 6;
  localparam int ERR_SOFT_FRM = 5;
  localparam int ERR_HARD_FRM = 4;
  localparam int ERR_WT = 3;
  localparam int ERR_WAM = 2;
  localparam int ERR_WPH = 1;
  localparam int ERR_WCAP = 0;

  // ==========================================================
  // queue flag register bit positions
  localparam int QF_UNF = 6;
  localparam int QF_OVR = 5;
  localparam int QF_NCP = 4;
  localparam int QF_LB_HI = 3;
  localparam int QF_LB_LO = 1;
  localparam int QF_NP = 0;

  // ==========================================================
  // control and main-summary bit positions
  localparam int CTRL_SET_DEFAULT = 0;
  localparam int CTRL_WT_EVERY = 1;
  localparam int MAIN_ERR = 0;

  // ==========================================================
  // sizes and reset values
  localparam logic [6:0] QUEUE_DEPTH = 7'h60;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  function automatic logic [7:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx[5:0], 2'b00};
  endfunction : byte_addr

  // ==========================================================
  // types
  typedef enum logic {
    WT_IDLE = 1'b0,
    WT_ARMED = 1'b1
  } ewifs_wt_state_t;

  typedef struct packed {
    logic crc;
    logic par;
    logic soft_framing;
    logic hard_framing;
  } ewifs_rx_err_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
    logic [7:0] reference;
    logic [7:0] delta;
  } ewifs_meas_t;

  typedef struct packed {
    logic valid;
    logic [2:0] nbits;
    logic missing_parity;
    logic [7:0] raw;
  } ewifs_last_byte_t;

endpackage : ewifs_pkg

`default_nettype wire

// ---- design/ewifs_status.sv ----
// error / wake-up interrupt status and receive queue status registers
// assumes APB master in the same clock domain, event inputs are
// one-cycle pulses synchronous to SYS_CLK_IN
//
// Register access over APB was decided locally.
`default_nettype none

module ewifs_status
  import ewifs_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // receive framing events
  input wire ewifs_rx_err_t RX_ERR_IN,
  // wake-up timer and measurements
  input wire logic WT_START_IN,
  input wire logic WT_STOP_IN,
  input wire logic WT_TIMEOUT_IN,
  input wire ewifs_meas_t AMP_MEAS_IN,
  input wire ewifs_meas_t PHASE_MEAS_IN,
  input wire ewifs_meas_t CAP_MEAS_IN,
  // receive queue activity
  input wire logic QUEUE_PUSH_IN,
  input wire logic QUEUE_POP_IN,
  input wire ewifs_last_byte_t LAST_BYTE_IN,
  // results
  output logic IRQ_OUT,
  output logic [6:0] QUEUE_COUNT_OUT,
  output logic [7:0] LAST_BYTE_OUT,
  output logic LAST_BYTE_VALID_OUT
);

  // ==========================================================
  // declarations
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic addr_hit;
  logic setup;
  logic access;
  logic rd_err;
  logic rd_flags;
  logic wr_mask;
  logic wr_ctrl;
  logic soft_clr;

  logic setdef_q;
  logic wt_every_q;
  logic [7:0] mask_q;
  logic [7:0] err_q;
  logic [7:0] err_d;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic sum_q;
  logic sum_d;
  logic irq_q;

  ewifs_wt_state_t wt_state_q;
  logic wt_hit;
  logic amp_hit;
  logic ph_hit;
  logic cap_hit;
  logic np_event;

  logic [6:0] count_q;
  logic [6:0] count_d;
  logic unf_q;
  logic ovr_q;
  logic unf_set;
  logic ovr_set;
  logic ncp_q;
  logic ncp_d;
  logic [2:0] lb_q;
  logic [2:0] lb_d;
  logic np_q;
  logic np_d;
  logic [7:0] flags_val;
  logic [7:0] packed_q;
  logic packed_valid_q;

  // ==========================================================
  // apb decode
  assign setup = PSEL_IN & ~PENABLE_IN;
  // side effects only at the completing edge of the access phase
  assign access = PSEL_IN & PENABLE_IN & pready_q;
  assign rd_err = access & ~PWRITE_IN & (PADDR_IN == byte_addr(IDX_ERR_WAKE));
  assign rd_flags = access & ~PWRITE_IN & (PADDR_IN == byte_addr(IDX_QFLAGS));
  assign wr_mask = access & PWRITE_IN & (PADDR_IN == byte_addr(IDX_ERR_MASK));
  assign wr_ctrl = access & PWRITE_IN & (PADDR_IN == byte_addr(IDX_CTRL));
  assign soft_clr = RESET_IN | setdef_q;

  assign flags_val = {1'b0, unf_q, ovr_q, ncp_q, lb_q, np_q};

  // read data is sampled in the setup cycle and held for the access phase
  always_comb begin
    addr_hit = 1'b1;
    rdata_d = RDATA_RESET;
    case (PADDR_IN)
      byte_addr(IDX_ERR_MASK): rdata_d[7:0] = mask_q;
      byte_addr(IDX_MAIN_IRQ): rdata_d[MAIN_ERR] = sum_q;
      byte_addr(IDX_ERR_WAKE): rdata_d[7:0] = err_q;
      byte_addr(IDX_QFILL): rdata_d[6:0] = count_q;
      byte_addr(IDX_QFLAGS): rdata_d[7:0] = flags_val;
      byte_addr(IDX_CTRL): rdata_d[CTRL_WT_EVERY] = wt_every_q;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rdata_q <= RDATA_RESET;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~addr_hit;
      if (setup) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ==========================================================
  // control and mask registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      setdef_q <= 1'b0;
      wt_every_q <= 1'b0;
      mask_q <= REG_RESET;
    end else begin
      setdef_q <= wr_ctrl & PWDATA_IN[CTRL_SET_DEFAULT];
      if (wr_ctrl) begin
        wt_every_q <= PWDATA_IN[CTRL_WT_EVERY];
      end
      if (wr_mask) begin
        mask_q <= PWDATA_IN[7:0];
      end
    end
  end

  // ==========================================================
  // wake-up timer arming
  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      wt_state_q <= WT_IDLE;
    end else begin
      case (wt_state_q)
        WT_IDLE: begin
          if (WT_START_IN) begin
            wt_state_q <= WT_ARMED;
          end
        end
        WT_ARMED: begin
          if (WT_STOP_IN) begin
            wt_state_q <= WT_IDLE;
          end
        end
        default: wt_state_q <= WT_IDLE;
      endcase
    end
  end

  // every timeout while armed, not just the first
  assign wt_hit = WT_TIMEOUT_IN & (wt_state_q == WT_ARMED) & wt_every_q;

  // ==========================================================
  // measurement comparators
  ewifs_delta_cmp #(.W(8)) u_amp_cmp (
    .meas_valid_in(AMP_MEAS_IN.valid),
    .value_in(AMP_MEAS_IN.value),
    .reference_in(AMP_MEAS_IN.reference),
    .delta_in(AMP_MEAS_IN.delta),
    .hit_out(amp_hit)
  );

  ewifs_delta_cmp #(.W(8)) u_phase_cmp (
    .meas_valid_in(PHASE_MEAS_IN.valid),
    .value_in(PHASE_MEAS_IN.value),
    .reference_in(PHASE_MEAS_IN.reference),
    .delta_in(PHASE_MEAS_IN.delta),
    .hit_out(ph_hit)
  );

  ewifs_delta_cmp #(.W(8)) u_cap_cmp (
    .meas_valid_in(CAP_MEAS_IN.valid),
    .value_in(CAP_MEAS_IN.value),
    .reference_in(CAP_MEAS_IN.reference),
    .delta_in(CAP_MEAS_IN.delta),
    .hit_out(cap_hit)
  );

  // ==========================================================
  // error and wake-up status
  assign np_event = LAST_BYTE_IN.valid & LAST_BYTE_IN.missing_parity;

  always_comb begin
    err_set = REG_RESET;
    err_set[ERR_CRC] = RX_ERR_IN.crc;
    err_set[ERR_PAR] = RX_ERR_IN.par;
    // missing parity is reported as a soft framing error
    err_set[ERR_SOFT_FRM] = RX_ERR_IN.soft_framing | np_event;
    err_set[ERR_HARD_FRM] = RX_ERR_IN.hard_framing;
    err_set[ERR_WT] = wt_hit;
    err_set[ERR_WAM] = amp_hit;
    err_set[ERR_WPH] = ph_hit;
    err_set[ERR_WCAP] = cap_hit;
    // only bits the host actually saw are cleared, so a late event survives
    err_clr = rd_err ? rdata_q[7:0] : REG_RESET;
    err_d = (err_q & ~err_clr) | err_set;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      err_q <= REG_RESET;
    end else begin
      err_q <= err_d;
    end
  end

  // ==========================================================
  // summary bit and interrupt request
  always_comb begin
    if (|(err_set & ~mask_q)) begin
      sum_d = 1'b1;
    end else if (rd_err) begin
      sum_d = 1'b0;
    end else begin
      sum_d = sum_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      sum_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sum_q <= sum_d;
      irq_q <= sum_d;
    end
  end

  // ==========================================================
  // unread byte count with underflow and overflow
  always_comb begin
    count_d = count_q;
    unf_set = 1'b0;
    ovr_set = 1'b0;
    if (QUEUE_PUSH_IN & ~QUEUE_POP_IN) begin
      if (count_q == QUEUE_DEPTH) begin
        ovr_set = 1'b1;
      end else begin
        count_d = count_q + 7'h01;
      end
    end else if (QUEUE_POP_IN & ~QUEUE_PUSH_IN) begin
      if (count_q == 7'h00) begin
        unf_set = 1'b1;
      end else begin
        count_d = count_q - 7'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      count_q <= 7'h00;
      unf_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      count_q <= count_d;
      unf_q <= unf_q | unf_set;
      ovr_q <= ovr_q | ovr_set;
    end
  end

  // ==========================================================
  // partial last byte information
  always_comb begin
    ncp_d = ncp_q;
    lb_d = lb_q;
    np_d = np_q;
    if (rd_flags & rdata_q[QF_NCP]) begin
      ncp_d = 1'b0;
    end
    if (rd_flags & (rdata_q[QF_LB_HI:QF_LB_LO] != 3'h0)) begin
      lb_d = 3'h0;
    end
    if (rd_flags & rdata_q[QF_NP]) begin
      np_d = 1'b0;
    end
    if (count_d == 7'h00) begin
      ncp_d = 1'b0;
      lb_d = 3'h0;
    end
    // a new last byte overrides any clear in the same cycle
    if (LAST_BYTE_IN.valid) begin
      ncp_d = (LAST_BYTE_IN.nbits != 3'h0);
      lb_d = LAST_BYTE_IN.nbits;
      np_d = LAST_BYTE_IN.missing_parity;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      ncp_q <= 1'b0;
      lb_q <= 3'h0;
      np_q <= 1'b0;
    end else begin
      ncp_q <= ncp_d;
      lb_q <= lb_d;
      np_q <= np_d;
    end
  end

  // ==========================================================
  // partial byte packing toward the lsb
  // raw bits arrive top-aligned; shift by (8 - n) mod 8, n = 0 is a full byte
  always_ff @(posedge SYS_CLK_IN) begin
    if (soft_clr) begin
      packed_q <= REG_RESET;
      packed_valid_q <= 1'b0;
    end else begin
      packed_valid_q <= LAST_BYTE_IN.valid;
      if (LAST_BYTE_IN.valid) begin
        packed_q <= LAST_BYTE_IN.raw >> (3'h0 - LAST_BYTE_IN.nbits);
      end
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA_OUT = rdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign IRQ_OUT = irq_q;
  assign QUEUE_COUNT_OUT = count_q;
  assign LAST_BYTE_OUT = packed_q;
  assign LAST_BYTE_VALID_OUT = packed_valid_q;

endmodule : ewifs_status

`default_nettype wire

// ---- sim/ewifs_host_model.sv ----
// host microcontroller model: apb master for the status registers
// assumes the bench treats 20 cycles without pready as a timeout
`default_nettype none
module ewifs_host_model (
  // bus
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output var logic psel_out,
  output var logic penable_out,
  output var logic pwrite_out,
  output var logic [7:0] paddr_out,
  output var logic [31:0] pwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ncp, last-byte and np flag bits clear on read (unf and ovr stay set), so the host keeps its own copy
  logic [7:0] flags_copy;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'hFF;
    pwdata_out = 32'hFFFFFFFF;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er, output logic to);
    int n;
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 20);
    rd = prdata_in;
    er = pslverr_in;
    to = (pready_in !== 1'b1);
    if (!w && a == 8'h6C) flags_copy = prdata_in[7:0];
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~wd;
  endtask : xfer
endmodule : ewifs_host_model
`default_nettype wire

// ---- sim/ewifs_status_assertions.sv ----
// checker for the status block, watching only its ports
// assumes one clock; a set-default write clears one cycle late
`default_nettype none
module ewifs_status_chk
  import ewifs_pkg::*;
(
  // clock, reset and bus
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  // events
  input wire ewifs_rx_err_t RX_ERR_IN,
  input wire logic WT_TIMEOUT_IN,
  input wire ewifs_meas_t AMP_MEAS_IN,
  input wire ewifs_meas_t PHASE_MEAS_IN,
  input wire ewifs_meas_t CAP_MEAS_IN,
  input wire logic QUEUE_PUSH_IN,
  input wire logic QUEUE_POP_IN,
  input wire ewifs_last_byte_t LAST_BYTE_IN,
  // results
  input wire logic IRQ_OUT,
  input wire logic [6:0] QUEUE_COUNT_OUT,
  input wire logic [7:0] LAST_BYTE_OUT,
  input wire logic LAST_BYTE_VALID_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // helpers
  logic acc, rd_err, sd_w, sd_q, noev;
  assign acc = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign rd_err = acc & !PWRITE_IN & (PADDR_IN == 8'h64);
  assign sd_w = acc & PWRITE_IN & (PADDR_IN == 8'h80) & PWDATA_IN[0];
  assign noev = !(|RX_ERR_IN) & !WT_TIMEOUT_IN & !AMP_MEAS_IN.valid
    & !PHASE_MEAS_IN.valid & !CAP_MEAS_IN.valid & !LAST_BYTE_IN.valid;
  // set-default acts like reset, so both its cycles are excluded
  always_ff @(posedge SYS_CLK_IN) sd_q <= sd_w;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN || sd_w || sd_q);
  sequence s_push; QUEUE_PUSH_IN && !QUEUE_POP_IN; endsequence
  sequence s_pop; QUEUE_POP_IN && !QUEUE_PUSH_IN; endsequence
  sequence s_rd_clean; (PSEL_IN && !PENABLE_IN && noev) ##1 (rd_err && noev); endsequence
  // ==========================================================
  // queue count
  AST_CNT_MAX: assert property (QUEUE_COUNT_OUT <= 7'h60)
    else $error("count above depth");
  AST_CNT_INC: assert property (s_push ##0 QUEUE_COUNT_OUT < 7'h60 |=>
    QUEUE_COUNT_OUT == $past(QUEUE_COUNT_OUT) + 7'h01) else $error("push miscounted");
  AST_CNT_DEC: assert property (s_pop ##0 QUEUE_COUNT_OUT != 7'h00 |=>
    QUEUE_COUNT_OUT == $past(QUEUE_COUNT_OUT) - 7'h01) else $error("pop miscounted");
  AST_CNT_FULL: assert property (s_push ##0 QUEUE_COUNT_OUT == 7'h60 |=>
    QUEUE_COUNT_OUT == 7'h60) else $error("count moved on overflow");
  AST_CNT_EMPTY: assert property (s_pop ##0 QUEUE_COUNT_OUT == 7'h00 |=>
    QUEUE_COUNT_OUT == 7'h00) else $error("count moved on underflow");
  // ==========================================================
  // summary and last byte
  AST_IRQ_HOLD: assert property (IRQ_OUT && !rd_err && !$past(rd_err) |=> IRQ_OUT)
    else $error("summary dropped without read");
  AST_IRQ_CLR: assert property (s_rd_clean |-> ##[1:2] !IRQ_OUT)
    else $error("summary kept after read");
  AST_LB_VALID: assert property (LAST_BYTE_IN.valid |=> LAST_BYTE_VALID_OUT)
    else $error("last byte valid missing");
  // a bit count of zero means a complete byte, which stays where it is
  AST_LB_ALIGN: assert property (LAST_BYTE_IN.valid |=> LAST_BYTE_OUT ==
    (($past(LAST_BYTE_IN.nbits) == 3'h0) ? $past(LAST_BYTE_IN.raw) :
    ($past(LAST_BYTE_IN.raw) >> (4'h8 - {1'b0, $past(LAST_BYTE_IN.nbits)}))))
    else $error("last byte not low aligned");
endmodule : ewifs_status_chk

bind ewifs_status ewifs_status_chk chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .RX_ERR_IN(RX_ERR_IN),
  .WT_TIMEOUT_IN(WT_TIMEOUT_IN), .AMP_MEAS_IN(AMP_MEAS_IN), .PHASE_MEAS_IN(PHASE_MEAS_IN),
  .CAP_MEAS_IN(CAP_MEAS_IN), .QUEUE_PUSH_IN(QUEUE_PUSH_IN), .QUEUE_POP_IN(QUEUE_POP_IN),
  .LAST_BYTE_IN(LAST_BYTE_IN), .IRQ_OUT(IRQ_OUT), .QUEUE_COUNT_OUT(QUEUE_COUNT_OUT),
  .LAST_BYTE_OUT(LAST_BYTE_OUT), .LAST_BYTE_VALID_OUT(LAST_BYTE_VALID_OUT));
`default_nettype wire

// ---- sim/tb_error_wakeup_irq_and_fifo_status.sv ----
// testbench for the error / wake-up and queue status block
// assumes the host model drives the bus; bench drives the events
`default_nettype none
module tb_error_wakeup_irq_and_fifo_status;
  import ewifs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] rx;
    logic [1:0] sel;
    logic [7:0] v, r, d, e;
  } ewifs_row_t;
  // strobe codes: {rx[3:0], start, stop, timeout, push, pop}
  localparam logic [8:0] PUSH = 9'h002;
  localparam logic [8:0] POP = 9'h001;
  logic clk = 1'b0, rst = 1'b1, psel, pen, pwr, prdy, perr, irq, lbv;
  logic wts = 1'b0, wtp = 1'b0, wtt = 1'b0, push = 1'b0, pop = 1'b0;
  logic [7:0] pa, lbo;
  logic [31:0] pwd, prd;
  logic [6:0] cnt;
  ewifs_rx_err_t rx = '0;
  ewifs_meas_t am = '0, ph = '0, cp = '0;
  ewifs_last_byte_t lb = '0;
  int fails = 0, tests_run = 0;
  ewifs_row_t rows [8] = '{'{4'h8, 2'h0, 8'h00, 8'h00, 8'h00, 8'h80},
    '{4'h4, 2'h0, 8'h00, 8'h00, 8'h00, 8'h40}, '{4'h2, 2'h0, 8'h00, 8'h00, 8'h00, 8'h20},
    '{4'h1, 2'h0, 8'h00, 8'h00, 8'h00, 8'h10}, '{4'h0, 2'h1, 8'h32, 8'h28, 8'h09, 8'h04},
    '{4'h0, 2'h1, 8'h32, 8'h28, 8'h0A, 8'h00}, '{4'h0, 2'h2, 8'h0A, 8'h1E, 8'h05, 8'h02},
    '{4'h0, 2'h3, 8'h14, 8'h0A, 8'h03, 8'h01}};
  always #50 clk = ~clk;
  ewifs_status dut_u (.SYS_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .RX_ERR_IN(rx), .WT_START_IN(wts), .WT_STOP_IN(wtp),
    .WT_TIMEOUT_IN(wtt), .AMP_MEAS_IN(am), .PHASE_MEAS_IN(ph), .CAP_MEAS_IN(cp),
    .QUEUE_PUSH_IN(push), .QUEUE_POP_IN(pop), .LAST_BYTE_IN(lb), .IRQ_OUT(irq),
    .QUEUE_COUNT_OUT(cnt), .LAST_BYTE_OUT(lbo), .LAST_BYTE_VALID_OUT(lbv));
  ewifs_host_model host_u (.clk_in(clk), .prdata_in(prd), .pready_in(prdy),
    .pslverr_in(perr), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
    .paddr_out(pa), .pwdata_out(pwd));
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] r, output logic e);
    logic to;
    host_u.xfer(w, a, {24'h0, d}, r, e, to);
    if (to) begin
      fails++;
      tally_and_finish();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    bus(1'b0, a, 8'h00, r, e);
    chk(r, {24'h0, exp});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask : wr
  task automatic strobe(input logic [8:0] v, input ewifs_last_byte_t l);
    @(posedge clk);
    {rx, wts, wtp, wtt, push, pop} <= v;
    lb <= l;
    @(posedge clk);
    {rx, wts, wtp, wtt, push, pop} <= 9'h000;
    lb <= '0;
  endtask : strobe
  // ==========================================================
  // main sequence
  initial begin
    ewifs_meas_t m;
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      rx <= rows[i].rx;
      m = '{1'b1, rows[i].v, rows[i].r, rows[i].d};
      if (rows[i].sel == 2'h1) am <= m;
      if (rows[i].sel == 2'h2) ph <= m;
      if (rows[i].sel == 2'h3) cp <= m;
      @(posedge clk);
      rx <= '0;
      am <= '0;
      ph <= '0;
      cp <= '0;
      @(posedge clk);
      chk({31'h0, irq}, {31'h0, rows[i].e != 8'h00});
      rd(8'h64, rows[i].e);
      rd(8'h64, 8'h00);
      chk({31'h0, irq}, 32'h0);
    end
    // reset in mid-run with state pending
    strobe(9'h100 | PUSH, '0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h64, 8'h00);
    rd(8'h68, 8'h00);
    rd(8'h6C, 8'h00);
    bus(1'b0, 8'h00, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // masked source and summary kept across other reads
    wr(8'h58, 8'h80);
    strobe(9'h100, '0);
    rd(8'h5C, 8'h00);
    rd(8'h64, 8'h80);
    wr(8'h58, 8'h00);
    strobe(9'h080, '0);
    rd(8'h68, 8'h00);
    rd(8'h5C, 8'h01);
    rd(8'h64, 8'h40);
    rd(8'h5C, 8'h00);
    // wake-up timer, every timeout while armed
    wr(8'h80, 8'h02);
    strobe(9'h010, '0);
    repeat (2) begin
      strobe(9'h004, '0);
      rd(8'h64, 8'h08);
    end
    strobe(9'h008, '0);
    strobe(9'h004, '0);
    rd(8'h64, 8'h00);
    // armed but with the every-timeout option off: no status bit
    wr(8'h80, 8'h00);
    strobe(9'h010, '0);
    strobe(9'h004, '0);
    rd(8'h64, 8'h00);
    // fill to overflow, then set-default
    repeat (97) strobe(PUSH, '0);
    rd(8'h68, 8'h60);
    chk({25'h0, cnt}, 32'h60);
    rd(8'h6C, 8'h20);
    strobe(9'h100, '0);
    wr(8'h80, 8'h01);
    rd(8'h64, 8'h00);
    rd(8'h68, 8'h00);
    rd(8'h6C, 8'h00);
    strobe(POP, '0);
    rd(8'h6C, 8'h40);
    // partial and parity-less last bytes
    strobe(PUSH, '{1'b1, 3'h3, 1'b0, 8'hA0});
    @(posedge clk);
    chk({23'h0, lbv, lbo}, 32'h105);
    rd(8'h68, 8'h01);
    rd(8'h6C, 8'h56);
    chk({24'h0, host_u.flags_copy}, 32'h56);
    rd(8'h6C, 8'h40);
    strobe(PUSH, '{1'b1, 3'h0, 1'b1, 8'h55});
    rd(8'h6C, 8'h41);
    rd(8'h64, 8'h20);
    rd(8'h6C, 8'h40);
    strobe(PUSH, '{1'b1, 3'h2, 1'b0, 8'hC0});
    repeat (3) strobe(POP, '0);
    rd(8'h68, 8'h00);
    rd(8'h6C, 8'h40);
    tally_and_finish();
  end
endmodule : tb_error_wakeup_irq_and_fifo_status
`default_nettype wire
